// >>> include/pwm_regs.svh
// Purpose: register map, field positions, reset values and timing figures of the fast pwm
// Assumes: byte-wide register port, 8-bit address
// Notes:   definitions only
`ifndef FAST_PWM_REGS_SVH
`define FAST_PWM_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define PWM_CONTROL_OFS     8'h0c
`define PWM_DUTY_CH0_OFS    8'h0d
`define PWM_DUTY_CH1_OFS    8'h0e
`define PWM_STATUS_OFS      8'h0f

// ****************************************
// control fields
// ****************************************
`define MODE_LSB            0
`define MODE_MSB            1
`define RUN_BIT             3
`define EN0_BIT             6
`define EN1_BIT             7

// ****************************************
// mode codes and period masks
// ****************************************
`define MODE_CODE_8BIT      2'h0
`define MODE_CODE_7BIT      2'h1
`define MODE_CODE_6BIT      2'h2
`define MODE_CODE_RSVD      2'h3
`define MASK_8BIT           8'hff
`define MASK_7BIT           8'h7f
`define MASK_6BIT           8'h3f

// ****************************************
// reset values
// ****************************************
`define CTRL_RESET          8'h00
`define DUTY_RESET          8'h00
`define READ_ZERO           8'h00

// ****************************************
// timing
// ****************************************
`define SRC_CLK_PERIOD_NS   50
`define MCLK_PERIOD_NS      10
`define SRC_CLK_CYCLES      (`SRC_CLK_PERIOD_NS / `MCLK_PERIOD_NS)

`endif

// >>> include/fast_pwm_pkg.sv
// Purpose: shared types of the fast pwm
// Assumes: pwm_regs.svh provides the codes
// Notes:   mode encodings follow the control field
`include "pwm_regs.svh"

package fast_pwm_pkg;
   typedef enum logic [1:0] {
      MODE_8BIT = `MODE_CODE_8BIT,
      MODE_7BIT = `MODE_CODE_7BIT,
      MODE_6BIT = `MODE_CODE_6BIT,
      MODE_RSVD = `MODE_CODE_RSVD
   } period_mode_type;
endpackage

// >>> design/src_tick_divider.sv
// Purpose: derives the source clock tick from mclk
// Assumes: one clock, synchronous active-high reset
// Notes:   phase is the mclk position inside the current source period
`timescale 1ns/1ps

module src_tick_divider #(
   parameter int unsigned DIV = 5,
   parameter int unsigned PW  = 8
) (
   input  wire logic          mclk,
   input  wire logic          reset,
   input  wire logic          clear,
   output logic              tick,
   output logic [PW-1:0]     phase
);
   initial begin
      if (DIV < 2 || DIV >= (1 << PW)) begin
         $error("src_tick_divider: DIV out of range");
      end
   end

   localparam logic [PW-1:0] LAST = PW'(DIV - 1);

   // ****************************************
   // phase counter
   // ****************************************
   always_ff @(posedge mclk) begin
      if (reset || clear) begin
         phase <= '0;
      end else if (phase == LAST) begin
         phase <= '0;
      end else begin
         phase <= phase + PW'(1);
      end
   end

   assign tick = (phase == LAST) && !clear;
endmodule

// >>> design/dual_channel_fast_pwm.sv
// Purpose: two-channel fast pwm with a shared up counter and 8/7/6-bit period modes
// Assumes: register port with read data one cycle after the read strobe
// Notes:   pins are active low pulses, idle high; half a source period is DIV/2 mclk, rounded down
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "pwm_regs.svh"

module dual_channel_fast_pwm
   import fast_pwm_pkg::*;
#(
   parameter int unsigned DIV = `SRC_CLK_CYCLES
) (
   input  wire logic          mclk,
   input  wire logic          reset,
   input  wire logic [7:0]    addr,
   input  wire logic [7:0]    wdata,
   input  wire logic          wr_en,
   input  wire logic          rd_en,
   output logic [7:0]         rdata,
   output logic              fast_pulse_out0,
   output logic              fast_pulse_out1
);
   localparam int unsigned       WW       = 16;
   localparam logic [WW-1:0]     DIV_W    = WW'(DIV);
   localparam logic [WW-1:0]     HALF_W   = WW'(DIV / 2);

   initial begin
      if (DIV < 2 || DIV > 200) begin
         $error("dual_channel_fast_pwm: DIV must lie in 2..200");
      end
   end

   // ****************************************
   // registers and state
   // ****************************************
   period_mode_type  mode_r;
   logic             run_r;
   logic             en0_r;
   logic             en1_r;
   logic [7:0]       duty0_r;
   logic [7:0]       duty1_r;
   logic [7:0]       count_r;
   logic             frame_r;
   logic             tick;
   logic [7:0]       phase;

   logic             ctrl_wr;
   logic             run_nxt;
   logic [1:0]       mode_wr;

   assign ctrl_wr = wr_en && (addr == `PWM_CONTROL_OFS);
   assign run_nxt = ctrl_wr ? wdata[`RUN_BIT] : run_r;
   assign mode_wr = wdata[`MODE_MSB:`MODE_LSB];

   // ****************************************
   // functions
   // ****************************************
   function automatic logic [7:0] period_mask(input period_mode_type m);
      logic [7:0] r;
      r = `MASK_8BIT;
      unique case (m)
         MODE_8BIT: r = `MASK_8BIT;
         MODE_7BIT: r = `MASK_7BIT;
         MODE_6BIT: r = `MASK_6BIT;
         MODE_RSVD: r = `MASK_8BIT;
      endcase
      return r;
   endfunction

   // control byte as software reads it back; unused bits read zero
   function automatic logic [7:0] ctrl_byte(input logic            e1,
                                            input logic            e0,
                                            input logic            r,
                                            input period_mode_type m);
      logic [7:0] b;
      b                      = `READ_ZERO;
      b[`EN1_BIT]            = e1;
      b[`EN0_BIT]            = e0;
      b[`RUN_BIT]            = r;
      b[`MODE_MSB:`MODE_LSB] = m;
      return b;
   endfunction

   // low width of one channel in mclk cycles for the current period
   function automatic logic [WW-1:0] width_cycles(input period_mode_type m,
                                                  input logic [7:0] d,
                                                  input logic f);
      logic [WW-1:0] base;
      logic [1:0]    halves;
      base   = '0;
      halves = 2'h0;
      unique case (m)
         MODE_8BIT: begin
            base = WW'(d);
         end
         MODE_7BIT: begin
            base   = WW'(d[7:1]);
            halves = {1'b0, d[0]};
         end
         // two-period pattern: first gets ceil(n/2) halves, second floor(n/2)
         MODE_6BIT: begin
            base   = WW'(d[7:2]);
            halves = f ? {1'b0, d[1]} : {1'b0, d[1]} + {1'b0, d[0]};
         end
         MODE_RSVD: begin
            base = WW'(d);
         end
      endcase
      return WW'(base * DIV_W) + WW'(WW'(halves) * HALF_W);
   endfunction

   // ****************************************
   // control register
   // ****************************************
   always_ff @(posedge mclk) begin
      if (reset) begin
         mode_r <= MODE_8BIT;
         run_r  <= 1'b0;
      end else if (ctrl_wr) begin
         run_r <= wdata[`RUN_BIT];
         if (!run_r && mode_wr != `MODE_CODE_RSVD) begin
            mode_r <= period_mode_type'(mode_wr);
         end
      end
   end

   // ****************************************
   // enables and duty registers
   // ****************************************
   always_ff @(posedge mclk) begin
      if (reset || !run_nxt) begin
         en0_r   <= 1'b0;
         en1_r   <= 1'b0;
         duty0_r <= `DUTY_RESET;
         duty1_r <= `DUTY_RESET;
      end else if (wr_en && run_r) begin
         if (addr == `PWM_CONTROL_OFS) begin
            en0_r <= wdata[`EN0_BIT];
            en1_r <= wdata[`EN1_BIT];
         end
         if (addr == `PWM_DUTY_CH0_OFS) begin
            duty0_r <= wdata;
         end
         if (addr == `PWM_DUTY_CH1_OFS) begin
            duty1_r <= wdata;
         end
      end
   end

   // ****************************************
   // source clock and shared counter
   // ****************************************
   src_tick_divider #(
      .DIV   (DIV),
      .PW    (8)
   ) u_div (
      .mclk  (mclk),
      .reset (reset),
      .clear (!run_r),
      .tick  (tick),
      .phase (phase)
   );

   always_ff @(posedge mclk) begin
      if (reset || !run_r) begin
         count_r <= '0;
         frame_r <= 1'b0;
      end else if (tick) begin
         if (count_r == period_mask(mode_r)) begin
            count_r <= '0;
            frame_r <= !frame_r;
         end else begin
            count_r <= count_r + 8'h01;
         end
      end
   end

   // ****************************************
   // output pins
   // ****************************************
   logic [WW-1:0] pos;
   logic          low0_nxt;
   logic          low1_nxt;

   assign pos = WW'(WW'(count_r) * DIV_W) + WW'(phase);

   // low first, then high
   // width follows the live duty value, so a mid-period write may cut one pulse
   assign low0_nxt = en0_r && (pos < width_cycles(mode_r, duty0_r, frame_r));
   assign low1_nxt = en1_r && (pos < width_cycles(mode_r, duty1_r, frame_r));

   always_ff @(posedge mclk) begin
      if (reset || !run_r) begin
         fast_pulse_out0 <= 1'b1;
      end else begin
         fast_pulse_out0 <= !low0_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset || !run_r) begin
         fast_pulse_out1 <= 1'b1;
      end else begin
         fast_pulse_out1 <= !low1_nxt;
      end
   end

   // ****************************************
   // read port
   // ****************************************
   always_ff @(posedge mclk) begin
      if (reset || !rd_en) begin
         rdata <= `READ_ZERO;
      end else begin
         unique case (addr)
            `PWM_CONTROL_OFS:  rdata <= ctrl_byte(en1_r, en0_r, run_r, mode_r);
            `PWM_DUTY_CH0_OFS: rdata <= duty0_r;
            `PWM_DUTY_CH1_OFS: rdata <= duty1_r;
            `PWM_STATUS_OFS:   rdata <= count_r;
            default:           rdata <= `READ_ZERO;
         endcase
      end
   end
endmodule

// >>> tb/fast_pwm_assertions.sv
// Purpose: port assertions of the fast pwm
// Assumes: one clock, reset held for more than one cycle
// Notes:   a shadow of registers and counter predicts the pins
`timescale 1ns/1ps

module fast_pwm_assertions
   import fast_pwm_pkg::*;
#(
   parameter int unsigned DIV = 5
) (
   input wire logic       mclk,
   input wire logic       reset,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr_en,
   input wire logic       rd_en,
   input wire logic [7:0] rdata,
   input wire logic       fast_pulse_out0,
   input wire logic       fast_pulse_out1
);
   logic            run_r;
   logic [1:0]      en_r;
   period_mode_type mode_r;
   logic [7:0]      duty_r [2];
   logic            frame_r;
   int              pos_r;
   int              per;
   int              wid [2];
   logic [1:0]      low;

   always_comb begin
      per = (256 >> mode_r) * DIV;
      for (int c = 0; c < 2; c++) begin
         if (mode_r == MODE_8BIT) wid[c] = duty_r[c] * DIV;
         else if (mode_r == MODE_7BIT) wid[c] = duty_r[c][7:1] * DIV + duty_r[c][0] * (DIV / 2);
         else wid[c] = duty_r[c][7:2] * DIV + (duty_r[c][1] + (duty_r[c][0] & !frame_r)) * (DIV / 2);
         low[c] = run_r && en_r[c] && pos_r < wid[c];
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         run_r  <= 1'b0;
         en_r   <= 2'h0;
         mode_r <= MODE_8BIT;
         duty_r <= '{8'h00, 8'h00};
      end else if (wr_en && addr == 8'h0c) begin
         run_r <= wdata[3];
         en_r  <= (run_r && wdata[3]) ? wdata[7:6] : 2'h0;
         if (!run_r && wdata[1:0] != 2'h3) mode_r <= period_mode_type'(wdata[1:0]);
         if (!wdata[3]) duty_r <= '{8'h00, 8'h00};
      end else if (wr_en && run_r && addr == 8'h0d) duty_r[0] <= wdata;
      else if (wr_en && run_r && addr == 8'h0e) duty_r[1] <= wdata;
   end

   // counter restarts whenever stopped, so the frame starts even
   always_ff @(posedge mclk) begin
      if (reset || !run_r || pos_r == per - 1) pos_r <= 0;
      else pos_r <= pos_r + 1;
      if (reset || !run_r) frame_r <= 1'b0;
      else if (pos_r == per - 1) frame_r <= !frame_r;
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (reset);

   property p_ctrl_read;
      rd_en && addr == 8'h0c |=> rdata == $past({en_r, 2'h0, run_r, 1'h0, mode_r});
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
   property p_duty_read;
      rd_en && addr == 8'h0d |=> rdata == $past(duty_r[0]);
   endproperty
   a_duty_read: assert property (p_duty_read) else $error("duty readback wrong");
   property p_count_read;
      rd_en && addr == 8'h0f |=> rdata == $past(8'(pos_r / DIV));
   endproperty
   a_count_read: assert property (p_count_read) else $error("counter value wrong");
   property p_stop_pins;
      !run_r |=> fast_pulse_out0 && fast_pulse_out1;
   endproperty
   a_stop_pins: assert property (p_stop_pins) else $error("pin low while stopped");
   property p_wave0;
      fast_pulse_out0 == !$past(low[0]);
   endproperty
   a_wave0: assert property (p_wave0) else $error("channel 0 waveform wrong");
   property p_wave1;
      fast_pulse_out1 == !$past(low[1]);
   endproperty
   a_wave1: assert property (p_wave1) else $error("channel 1 waveform wrong");
   property p_dis_high;
      !en_r[0] |=> fast_pulse_out0;
   endproperty
   a_dis_high: assert property (p_dis_high) else $error("disabled channel pulsed");
   property p_start_low;
      run_r && en_r[1] && pos_r == 0 && duty_r[1] != 8'h00 |=> !fast_pulse_out1 [*2];
   endproperty
   a_start_low: assert property (p_start_low) else $error("pulse not at period start");
endmodule

// >>> tb/pwm_load_model.sv
// Purpose: far-side load timing the low pulses of one pin
// Assumes: pin is active low, idle high
// Notes:   pair_len sums the last two pulses, so dither averages out
`timescale 1ns/1ps

module pwm_load_model (
   input  wire logic mclk,
   input  wire logic pin,
   output int        pair_len,
   output int        per_len
);
   // port latch set, pin idles high
   logic pin_q = 1'b1;
   int   lo_cnt = 0;
   int   per_cnt = 0;
   int   last_len = 0;

   always @(posedge mclk) begin
      pin_q   <= pin;
      lo_cnt  <= pin ? 0 : lo_cnt + 1;
      per_cnt <= (pin_q && !pin) ? 1 : per_cnt + 1;
      if (!pin_q && pin) begin
         last_len <= lo_cnt;
         pair_len <= lo_cnt + last_len;
      end
      if (pin_q && !pin) per_len <= per_cnt;
   end
endmodule

// >>> tb/tb.sv
// Purpose: register-level test of the fast pwm
// Assumes: 100 MHz mclk, DIV of 5
// Notes:   widths are judged two pulses at a time
`timescale 1ns/1ps

module tb;
   localparam int unsigned DIV = 5;
   logic       mclk = 1'b0;
   logic       reset = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr_en = 1'b0;
   logic       rd_en = 1'b0;
   logic [7:0] rdata;
   logic       fast_pulse_out0;
   logic       fast_pulse_out1;
   int         errors = 0;
   int         check_count = 0;
   int         pair_len [2];
   int         per_len [2];

   always #5 mclk = ~mclk;

   dual_channel_fast_pwm #(.DIV(DIV)) dual_channel_fast_pwm_i (.mclk(mclk), .reset(reset), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .fast_pulse_out0(fast_pulse_out0),
      .fast_pulse_out1(fast_pulse_out1));
   pwm_load_model load0_i (.mclk(mclk), .pin(fast_pulse_out0), .pair_len(pair_len[0]), .per_len(per_len[0]));
   pwm_load_model load1_i (.mclk(mclk), .pin(fast_pulse_out1), .pair_len(pair_len[1]), .per_len(per_len[1]));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wr_en <= 1'b1;
      rd_en <= 1'b0;
      addr  <= a;
      wdata <= d;
      @(posedge mclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      rd_en <= 1'b1;
      wr_en <= 1'b0;
      addr  <= a;
      @(posedge mclk);
      rd_en <= 1'b0;
      @(posedge mclk);
      check(rdata, exp);
   endtask

   task automatic cyc(input int n);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      repeat (n) @(posedge mclk);
   endtask

   // sum of two successive widths in mclk cycles
   function automatic int pair_exp(input int m, input logic [7:0] d);
      if (m == 0) return 2 * d * DIV;
      if (m == 1) return 2 * (d[7:1] * DIV + d[0] * (DIV / 2));
      return 2 * d[7:2] * DIV + (2 * d[1] + d[0]) * (DIV / 2);
   endfunction

   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      rd(8'h0c, 8'h00);
      rd(8'h20, 8'h00);
      wr(8'h0d, 8'h40);
      rd(8'h0d, 8'h00);
      for (int m = 0; m < 3; m++) begin
         wr(8'h0c, 8'(m));
         wr(8'h0c, 8'h08 | 8'(m));
         wr(8'h0c, 8'hc8 | 8'(m));
         wr(8'h0d, 8'h11);
         wr(8'h0e, 8'he7);
         wr(8'h0c, 8'hc8 | 8'(m ^ 1));
         rd(8'h0c, 8'hc8 | 8'(m));
         cyc(3 * (256 >> m) * DIV);
         for (int c = 0; c < 2; c++) begin
            check(per_len[c], (256 >> m) * DIV);
            check(pair_len[c], pair_exp(m, c ? 8'he7 : 8'h11));
         end
         wr(8'h0c, 8'(m));
         rd(8'h0c, 8'(m));
         rd(8'h0e, 8'h00);
         rd(8'h0f, 8'h00);
         check({fast_pulse_out0, fast_pulse_out1}, 2'h3);
      end
      wr(8'h0c, 8'h03);
      rd(8'h0c, 8'h02);
      cyc(1);
      end_of_test();
   end
endmodule

bind dual_channel_fast_pwm fast_pwm_assertions #(.DIV(DIV)) fast_pwm_assertions_i (.mclk(mclk), .reset(reset),
   .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .fast_pulse_out0(fast_pulse_out0),
   .fast_pulse_out1(fast_pulse_out1));
